// ---- design/rbdm_rx_desc_mgr.sv ----
// Receive buffer descriptor manager: list walk, buffer fill, status write-back
//
// The APB register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module rbdm_rx_desc_mgr #(
    parameter int BUF_WORDS = rbdm_pkg::BUF_WORDS
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic rx_start, // Frame began entering FIFO
    input wire logic rx_copy, // Filter accepts frame
    input wire logic rx_reject, // Filter rejects frame
    input wire logic rx_err, // Receive error
    input wire logic rx_valid, // Data word valid
    input wire logic [31:0] rx_word, // Data word
    input wire logic rx_last, // Last word of frame
    input wire logic rx_fcs, // Word holds only FCS
    input wire logic [13:0] rx_len, // Frame length with FCS
    input wire logic [15:0] rx_type, // Type field
    input wire logic [11:0] rx_vid, // VLAN identifier
    input wire logic [2:0] rx_pcp, // VLAN priority
    input wire logic rx_cfi, // Format indicator
    input wire logic rx_tid, // Type ID match
    input wire logic [8:0] rx_match, // Address match flags
    output logic rx_ready, // Data word accepted
    output logic mem_req, // Memory request
    output logic mem_we, // Memory write
    output logic [31:0] mem_addr, // Memory byte address
    output logic [31:0] mem_wdata, // Memory write data
    input wire logic [31:0] mem_rdata, // Memory read data
    input wire logic mem_ack, // Memory done
    input wire logic mem_err, // Bus error response
    input wire logic mem_late, // Grant too late
    output logic bna_evt, // Buffer not available pulse
    output logic ovr_evt, // Overrun pulse
    output logic rse_evt // Resource error pulse
);
    if (BUF_WORDS < 2 || BUF_WORDS > 63) begin : g_bad
        $error("BUF_WORDS out of range");
    end

    rbdm_pkg::rbdm_state_t st_r, st_nxt;
    logic [31:0] cfg_w, base_w, fmt_w, d0_r, stat_r;
    logic qptr_wr_w;
    logic [10:0] cnt_r, cnt_nxt;
    logic [5:0] wcnt_r, wcnt_nxt;
    logic sof_r, ferr_r, last_r, last_nxt;

    wire [31:0] ptr_w = base_w + {19'h0_0000, cnt_r, 2'b00};
    wire [31:0] ptr_nxt_w = base_w + {19'h0_0000, cnt_nxt, 2'b00};
    wire take_w = rx_valid && rx_ready;
    wire drop_w = rx_fcs && cfg_w[rbdm_pkg::CFG_STRIP];
    wire fail_w = mem_req && (mem_err || mem_late);
    wire done_w = mem_req && mem_ack && !fail_w;
    wire full_w = (wcnt_r == 6'(BUF_WORDS));
    wire used_w = d0_r[rbdm_pkg::D0_USED];
    wire [31:0] buf_w = {d0_r[31:2], 2'b00} + {24'h00_0000, wcnt_r, 2'b00};
    wire issue_w = (st_nxt != st_r) && (st_nxt == rbdm_pkg::ST_FETCH ||
                   st_nxt == rbdm_pkg::ST_WDAT || st_nxt == rbdm_pkg::ST_WSTAT ||
                   st_nxt == rbdm_pkg::ST_WOWN);

    rbdm_apb_regs u_regs (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .cfg(cfg_w),
        .base(base_w),
        .qptr_wr(qptr_wr_w),
        .cur_ptr(ptr_w),
        .bna_evt(bna_evt),
        .ovr_evt(ovr_evt),
        .rse_evt(rse_evt)
    );

    rbdm_status_fmt u_fmt (
        .eof(rx_last),
        .sof(sof_r),
        .ofs(cfg_w[rbdm_pkg::CFG_OFS_LO +: 2]),
        .jumbo(cfg_w[rbdm_pkg::CFG_JUMBO]),
        .strip(cfg_w[rbdm_pkg::CFG_STRIP]),
        .len(rx_len),
        .ftype(rx_type),
        .vid(rx_vid),
        .pcp(rx_pcp),
        .cfi(rx_cfi),
        .tid(rx_tid),
        .match(rx_match),
        .word(fmt_w)
    );

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            rbdm_pkg::ST_IDLE: begin
                if (rx_start && cfg_w[rbdm_pkg::CFG_RXEN]) begin
                    st_nxt = rbdm_pkg::ST_FETCH;
                end
            end
            rbdm_pkg::ST_FETCH: begin
                if (fail_w) begin
                    st_nxt = rbdm_pkg::ST_DROP;
                end else if (done_w) begin
                    st_nxt = rbdm_pkg::ST_CHECK;
                end
            end
            rbdm_pkg::ST_CHECK: begin
                if (used_w) begin
                    st_nxt = rbdm_pkg::ST_DROP;
                end else if (sof_r) begin
                    st_nxt = rbdm_pkg::ST_WCOPY;
                end else begin
                    st_nxt = rbdm_pkg::ST_DATA;
                end
            end
            rbdm_pkg::ST_WCOPY: begin
                if (ferr_r || rx_err || rx_reject) begin
                    st_nxt = rbdm_pkg::ST_IDLE;
                end else if (rx_copy) begin
                    st_nxt = rbdm_pkg::ST_DATA;
                end
            end
            rbdm_pkg::ST_DATA: begin
                if (ferr_r || rx_err) begin
                    st_nxt = rbdm_pkg::ST_IDLE;
                end else if (last_r || full_w) begin
                    st_nxt = rbdm_pkg::ST_WSTAT;
                end else if (take_w && !drop_w) begin
                    st_nxt = rbdm_pkg::ST_WDAT;
                end
            end
            rbdm_pkg::ST_WDAT, rbdm_pkg::ST_WSTAT: begin
                if (fail_w) begin
                    st_nxt = rbdm_pkg::ST_DROP;
                end else if (done_w) begin
                    st_nxt = (st_r == rbdm_pkg::ST_WDAT) ? rbdm_pkg::ST_DATA : rbdm_pkg::ST_WOWN;
                end
            end
            rbdm_pkg::ST_WOWN: begin
                if (fail_w) begin
                    st_nxt = rbdm_pkg::ST_DROP;
                end else if (done_w) begin
                    st_nxt = last_r ? rbdm_pkg::ST_IDLE : rbdm_pkg::ST_FETCH;
                end
            end
            rbdm_pkg::ST_DROP: begin
                if (ferr_r || rx_err || last_r || (take_w && rx_last)) begin
                    st_nxt = rbdm_pkg::ST_IDLE;
                end
            end
            default: st_nxt = rbdm_pkg::ST_IDLE;
        endcase
    end

    // wrap bit or counter rollover restarts list
    assign cnt_nxt = qptr_wr_w ? 11'h000 :
                     (st_r == rbdm_pkg::ST_WOWN && done_w) ?
                     (d0_r[rbdm_pkg::D0_WRAP] ? 11'h000 : cnt_r + rbdm_pkg::DESC_STEP) : cnt_r;
    assign wcnt_nxt = (st_r == rbdm_pkg::ST_CHECK) ? 6'h00 :
                      (st_r == rbdm_pkg::ST_WDAT && done_w) ? wcnt_r + 6'h01 : wcnt_r;
    assign last_nxt = (st_r == rbdm_pkg::ST_IDLE && rx_start) ? 1'b0 :
                      take_w ? rx_last : last_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= rbdm_pkg::ST_IDLE;
            cnt_r <= 11'h000;
            wcnt_r <= 6'h00;
            last_r <= 1'b0;
            rx_ready <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            wcnt_r <= wcnt_nxt;
            last_r <= last_nxt;
            // Ready is precomputed so a full buffer never takes an extra word
            rx_ready <= !last_nxt && (st_nxt == rbdm_pkg::ST_DROP ||
                        (st_nxt == rbdm_pkg::ST_DATA && wcnt_nxt != 6'(BUF_WORDS)));
        end
    end

    // Frame flags; a receive error wins over the restart clear
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sof_r <= 1'b0;
            ferr_r <= 1'b0;
            d0_r <= 32'h0000_0000;
            stat_r <= 32'h0000_0000;
        end else begin
            ferr_r <= rx_err || (ferr_r && !(st_r == rbdm_pkg::ST_IDLE && rx_start));
            if (st_r == rbdm_pkg::ST_IDLE && rx_start) begin
                sof_r <= 1'b1;
            end else if (st_r == rbdm_pkg::ST_WOWN && done_w) begin
                sof_r <= 1'b0;
            end
            if (st_r == rbdm_pkg::ST_FETCH && done_w) begin
                d0_r <= mem_rdata;
            end
            if (take_w) begin
                stat_r <= fmt_w;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
        end else if (issue_w) begin
            mem_req <= 1'b1;
            mem_we <= (st_nxt != rbdm_pkg::ST_FETCH);
            case (st_nxt)
                // descriptor address from base and counter
                rbdm_pkg::ST_FETCH: mem_addr <= ptr_nxt_w;
                rbdm_pkg::ST_WDAT: mem_addr <= buf_w;
                rbdm_pkg::ST_WSTAT: mem_addr <= ptr_w + 32'h0000_0004;
                default: mem_addr <= ptr_w;
            endcase
            mem_wdata <= (st_nxt == rbdm_pkg::ST_WDAT) ? rx_word :
                         (st_nxt == rbdm_pkg::ST_WSTAT) ? stat_r :
                         (d0_r | 32'h0000_0001);
        end else if (done_w || fail_w) begin
            mem_req <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bna_evt <= 1'b0;
            rse_evt <= 1'b0;
            ovr_evt <= 1'b0;
        end else begin
            bna_evt <= (st_r == rbdm_pkg::ST_CHECK) && used_w;
            rse_evt <= (st_r == rbdm_pkg::ST_CHECK) && used_w;
            ovr_evt <= fail_w;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_fetch_issue;
        mem_req && !mem_we && (mem_addr == ptr_w);
    endsequence

    a_fetch_on_start: assert property (
        (st_r == rbdm_pkg::ST_IDLE && rx_start && cfg_w[rbdm_pkg::CFG_RXEN] && !qptr_wr_w)
        |=> s_fetch_issue) else $error("no descriptor fetch after frame start");
    a_no_early_write: assert property (
        (st_r == rbdm_pkg::ST_WCOPY) |-> !(mem_req && mem_we)) else $error("write before copy");
    a_used_bit_set: assert property (
        (mem_req && st_r == rbdm_pkg::ST_WOWN) |-> mem_we && mem_wdata[0])
        else $error("used bit not written");
    a_wrap_clears: assert property (
        (st_r == rbdm_pkg::ST_WOWN && done_w && d0_r[1] && !qptr_wr_w) |=> cnt_r == 11'h000)
        else $error("counter not cleared on wrap");
    a_list_step: assert property (
        (st_r == rbdm_pkg::ST_WOWN && done_w && !d0_r[1] && !qptr_wr_w)
        |=> cnt_r == $past(cnt_r) + 11'h002) else $error("counter did not step");
    a_bna_discard: assert property (
        (st_r == rbdm_pkg::ST_CHECK && used_w) |=> bna_evt && rse_evt && st_r == rbdm_pkg::ST_DROP)
        else $error("used descriptor not handled");
    a_ovr_on_fail: assert property (
        fail_w |=> ovr_evt && !mem_req ##1 !ovr_evt) else $error("overrun not flagged");
    a_partial_status: assert property (
        (mem_req && st_r == rbdm_pkg::ST_WSTAT && !mem_wdata[rbdm_pkg::ST_EOF])
        |-> (mem_wdata & ~rbdm_pkg::ST_PART_MASK) == 32'h0000_0000)
        else $error("partial status has extra bits");
endmodule
`default_nettype wire

// ---- design/rbdm_pkg.sv ----
// Constants, layouts and states of the receive descriptor manager
package rbdm_pkg;
    // Register byte offsets on the APB slave
    localparam logic [11:0] OFS_CFG = 12'h000;
    localparam logic [11:0] OFS_QPTR = 12'h004;
    localparam logic [11:0] OFS_STAT = 12'h008;
    localparam logic [11:0] OFS_RSERR = 12'h00C;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] QPTR_RST = 32'h0000_0000;
    // Configuration bits
    localparam int CFG_RXEN = 0;
    localparam int CFG_JUMBO = 3;
    localparam int CFG_OFS_LO = 14;
    localparam int CFG_STRIP = 17;
    // Status register bits
    localparam int STAT_BNA = 0;
    localparam int STAT_OVR = 1;
    // Descriptor word 0 and word 1 layout
    localparam int D0_USED = 0;
    localparam int D0_WRAP = 1;
    localparam int ST_MATCH_LO = 23;
    localparam int ST_TYPE = 22;
    localparam int ST_VLAN = 21;
    localparam int ST_PRIO = 20;
    localparam int ST_VPRI_LO = 17;
    localparam int ST_CFI = 16;
    localparam int ST_EOF = 15;
    localparam int ST_SOF = 14;
    localparam int ST_OFS_LO = 12;
    localparam logic [31:0] ST_PART_MASK = 32'h0000_7000;
    localparam logic [15:0] VLAN_TPID = 16'h8100;
    localparam logic [13:0] FCS_BYTES = 14'h0004;
    localparam int BUF_WORDS = 32;
    localparam logic [10:0] DESC_STEP = 11'h002;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_FETCH = 4'h1,
        ST_CHECK = 4'h3,
        ST_WCOPY = 4'h2,
        ST_DATA = 4'h6,
        ST_WDAT = 4'h7,
        ST_WSTAT = 4'h5,
        ST_WOWN = 4'h4,
        ST_DROP = 4'hC
    } rbdm_state_t;
endpackage

// ---- design/rbdm_status_fmt.sv ----
// Builds the descriptor status word for one buffer
`timescale 1ns/100ps
`default_nettype none
module rbdm_status_fmt (
    input wire logic eof, // Buffer ends the frame
    input wire logic sof, // Buffer starts the frame
    input wire logic [1:0] ofs, // First-buffer byte offset
    input wire logic jumbo, // Jumbo mode
    input wire logic strip, // FCS not copied
    input wire logic [13:0] len, // Frame length with FCS
    input wire logic [15:0] ftype, // Frame type field
    input wire logic [11:0] vid, // VLAN identifier
    input wire logic [2:0] pcp, // VLAN priority
    input wire logic cfi, // Format indicator
    input wire logic tid, // Type ID match
    input wire logic [8:0] match, // Address match flags, bit 4 unused
    output logic [31:0] word // Status word
);
    logic [13:0] len_w;
    logic vlan_w;
    logic [31:0] full_w;
    logic [31:0] part_w;
    assign len_w = strip ? len - rbdm_pkg::FCS_BYTES : len;
    assign vlan_w = (ftype == rbdm_pkg::VLAN_TPID);
    assign part_w = {16'h0000, 1'b0, sof, ofs, 12'h000};
    always_comb begin
        full_w = 32'h0000_0000;
        full_w[31:rbdm_pkg::ST_MATCH_LO] = {match[8:5], 1'b0, match[3:0]};
        full_w[rbdm_pkg::ST_TYPE] = tid;
        full_w[rbdm_pkg::ST_VLAN] = vlan_w;
        full_w[rbdm_pkg::ST_PRIO] = vlan_w && (vid == 12'h000);
        full_w[rbdm_pkg::ST_VPRI_LO +: 3] = vlan_w ? pcp : 3'h0;
        full_w[rbdm_pkg::ST_CFI] = vlan_w && cfi;
        full_w[rbdm_pkg::ST_EOF] = 1'b1;
        full_w[rbdm_pkg::ST_SOF] = sof;
        full_w[rbdm_pkg::ST_OFS_LO +: 2] = jumbo ? len_w[13:12] : ofs;
        full_w[11:0] = len_w[11:0];
    end
    assign word = eof ? full_w : part_w;
endmodule
`default_nettype wire

// ---- design/rbdm_apb_regs.sv ----
// APB register slave of the receive descriptor manager
`timescale 1ns/100ps
`default_nettype none
module rbdm_apb_regs (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    output logic [31:0] cfg, // Configuration
    output logic [31:0] base, // List base
    output logic qptr_wr, // Base written pulse
    input wire logic [31:0] cur_ptr, // Entry being accessed
    input wire logic bna_evt, // Buffer not available
    input wire logic ovr_evt, // Overrun
    input wire logic rse_evt // Resource error
);
    logic [1:0] stat_r;
    logic [15:0] rse_r;
    logic [31:0] rd_w;
    logic hit_w;
    logic wr_w;
    logic setup_w;
    assign setup_w = psel && !penable;
    assign wr_w = psel && penable && pready && pwrite;
    assign hit_w = (paddr == rbdm_pkg::OFS_CFG) || (paddr == rbdm_pkg::OFS_QPTR) ||
                   (paddr == rbdm_pkg::OFS_STAT) || (paddr == rbdm_pkg::OFS_RSERR);
    assign rd_w = (paddr == rbdm_pkg::OFS_CFG) ? cfg :
                  (paddr == rbdm_pkg::OFS_QPTR) ? cur_ptr :
                  (paddr == rbdm_pkg::OFS_STAT) ? {30'h0000_0000, stat_r} :
                  (paddr == rbdm_pkg::OFS_RSERR) ? {16'h0000, rse_r} : 32'h0000_0000;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup_w;
            pslverr <= setup_w && !hit_w;
            prdata <= (setup_w && !pwrite) ? rd_w : 32'h0000_0000;
        end
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= rbdm_pkg::CFG_RST;
            base <= rbdm_pkg::QPTR_RST;
            qptr_wr <= 1'b0;
        end else begin
            qptr_wr <= wr_w && (paddr == rbdm_pkg::OFS_QPTR);
            if (wr_w && (paddr == rbdm_pkg::OFS_CFG)) begin
                cfg <= pwdata;
            end
            if (wr_w && (paddr == rbdm_pkg::OFS_QPTR)) begin
                base <= {pwdata[31:2], 2'b00};
            end
        end
    end
    // Sticky flags clear by writing one; a new event wins over the clear; the resource error count never clears
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stat_r <= 2'b00;
            rse_r <= 16'h0000;
        end else begin
            stat_r <= (stat_r & ~((wr_w && paddr == rbdm_pkg::OFS_STAT) ? pwdata[1:0] : 2'b00))
                      | {ovr_evt, bna_evt};
            rse_r <= rse_r + {15'h0000, rse_evt};
        end
    end
endmodule
`default_nettype wire

// ---- dv/rbdm_mem_model.sv ----
// Behavioural system memory answering the manager's single-word requests
`timescale 1ns/100ps
`default_nettype none
module rbdm_mem_model (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset
    input wire logic mem_req, // Request level
    input wire logic mem_we, // Write
    input wire logic [31:0] mem_addr, // Byte address
    input wire logic [31:0] mem_wdata, // Write data
    input wire logic [1:0] slow, // Extra wait cycles
    input wire logic [1:0] fail, // 1 bus error, 2 late grant
    output logic [31:0] mem_rdata, // Read data
    output logic mem_ack, // Done
    output logic mem_err, // Error response
    output logic mem_late // Grant too late
);
    logic [31:0] mem [0:4095];
    logic [1:0] wait_r;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            mem_late <= 1'b0;
            wait_r <= 2'h0;
            mem_rdata <= 32'h0;
        end else begin
            mem_ack <= 1'b0;
            mem_err <= 1'b0;
            mem_late <= 1'b0;
            // Stale read data toggles so it never passes for an answer
            mem_rdata <= ~mem_rdata;
            if (mem_req && !(mem_ack || mem_err || mem_late)) begin
                wait_r <= (wait_r == slow) ? 2'h0 : wait_r + 2'h1;
                if (wait_r == slow) begin
                    mem_err <= fail == 2'h1;
                    mem_late <= fail == 2'h2;
                    mem_ack <= fail == 2'h0;
                    if (fail == 2'h0 && mem_we) mem[mem_addr[13:2]] <= mem_wdata;
                    if (fail == 2'h0 && !mem_we) mem_rdata <= mem[mem_addr[13:2]];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/rbdm_rx_desc_mgr_tb_top.sv ----
// Self-checking bench of the receive descriptor manager
`timescale 1ns/100ps
`default_nettype none
module rbdm_rx_desc_mgr_tb_top;
    localparam int BUF = rbdm_pkg::BUF_WORDS;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, e_v, bna_s, rse_s;
    logic [11:0] paddr, rx_vid;
    logic [31:0] pwdata, prdata, rx_word, mem_addr, mem_wdata, mem_rdata, cfg_v, rd_v;
    logic rx_start, rx_copy, rx_reject, rx_err, rx_valid, rx_last, rx_fcs, rx_cfi, rx_tid;
    logic rx_ready, mem_req, mem_we, mem_ack, mem_err, mem_late, bna_evt, ovr_evt, rse_evt;
    logic [13:0] rx_len;
    logic [15:0] rx_type;
    logic [2:0] rx_pcp;
    logic [8:0] rx_match;
    logic [1:0] slow, fail;
    logic [31:0] wq [$];
    int err_total, samples_checked, n;

    rbdm_rx_desc_mgr u_rbdm_rx_desc_mgr (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .rx_start, .rx_copy, .rx_reject, .rx_err, .rx_valid,
        .rx_word, .rx_last, .rx_fcs, .rx_len, .rx_type, .rx_vid, .rx_pcp, .rx_cfi, .rx_tid,
        .rx_match, .rx_ready, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack,
        .mem_err, .mem_late, .bna_evt, .ovr_evt, .rse_evt);
    rbdm_mem_model u_rbdm_mem_model (.clk_sys, .rst_n, .mem_req, .mem_we, .mem_addr, .mem_wdata,
        .slow, .fail, .mem_rdata, .mem_ack, .mem_err, .mem_late);

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd_v = prdata;
        e_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_v, exp, "register read");
    endtask

    function automatic logic [31:0] st_exp(input logic sof, input logic eof, input logic [13:0] l);
        logic [31:0] s;
        s = 32'h0;
        s[14] = sof;
        s[13:12] = cfg_v[3] ? l[13:12] : cfg_v[15:14];
        if (eof) begin
            s = s | {rx_match[8:5], 1'b0, rx_match[3:0], rx_tid, 2'b00, rx_pcp, rx_cfi, 16'h8000};
            s[21] = rx_type == 16'h8100;
            s[20] = s[21] && rx_vid == 12'h0;
            s[11:0] = l[11:0];
        end
        return s;
    endfunction

    task automatic begin_frame(input logic [31:0] ptr);
        int k;
        logic u;
        u = u_rbdm_mem_model.mem[ptr[13:2]][0];
        @(posedge clk_sys);
        rx_start <= 1'b1;
        @(posedge clk_sys);
        rx_start <= 1'b0;
        for (k = 0; k < 60 && !(mem_ack && !mem_we); k++) @(posedge clk_sys);
        chk(mem_addr, ptr, "fetch address");
        {bna_s, rse_s} = 2'b00;
        for (k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            bna_s |= bna_evt;
            rse_s |= rse_evt;
            // A used entry drops the frame, which takes its one pending last beat
            chk(32'(rx_ready), 32'(u && k == 1), "beat taken before copy");
        end
    endtask

    task automatic frame(input int cnt, input int d, input logic st);
        int i;
        wq.delete();
        for (i = 0; i < cnt; i++) wq.push_back($urandom);
        slow <= 2'($urandom);
        rx_len <= 14'(cnt * 4);
        rx_valid <= 1'b1;
        rx_word <= wq[0];
        rx_last <= cnt == 1;
        rx_fcs <= st && cnt == 1;
        begin_frame(32'h100 + d * 8);
        rx_copy <= 1'b1;
        i = 0;
        while (i < cnt) begin
            @(posedge clk_sys);
            if (rx_ready) begin
                if (i == 0) rx_copy <= 1'b0;
                i++;
                if (i < cnt) rx_word <= wq[i];
                rx_last <= i == cnt - 1;
                rx_fcs <= st && i == cnt - 1;
            end
        end
        rx_valid <= 1'b0;
    endtask

    task automatic chk_buf(input int d, input int first, input int cnt, input logic sof,
        input logic eof, input logic [13:0] l);
        int i;
        for (i = 0; i < 400 && u_rbdm_mem_model.mem[64 + 2 * d][0] !== 1'b1; i++)
            @(posedge clk_sys);
        chk(u_rbdm_mem_model.mem[64 + 2 * d], 32'h401 + d * 128 + (d == 2 ? 2 : 0), "used");
        for (i = 0; i < cnt; i++)
            chk(u_rbdm_mem_model.mem[256 + 32 * d + i], wq[first + i], "data");
        chk(u_rbdm_mem_model.mem[65 + 2 * d], st_exp(sof, eof, l), "status");
    endtask

    // Kinds: 1 bus error, 2 late grant, 3 receive error, 4 filter reject
    task automatic abort(input int kind);
        int k;
        logic seen;
        seen = 1'b0;
        rx_valid <= 1'b1;
        rx_last <= 1'b0;
        rx_fcs <= 1'b0;
        begin_frame(32'h100);
        for (k = 0; k < 60; k++) begin
            rx_copy <= kind < 4 && k == 0;
            rx_reject <= kind == 4 && k == 0;
            rx_err <= kind == 3 && k == 6;
            // Ends a dropped frame, else the next start is ignored
            rx_last <= k == 59;
            fail <= kind < 3 ? 2'(kind) : 2'h0;
            @(posedge clk_sys);
            seen |= ovr_evt;
        end
        fail <= 2'h0;
        rx_valid <= 1'b0;
        chk(32'(seen), 32'(kind < 3), "overrun pulse");
        rd(rbdm_pkg::OFS_QPTR, 32'h100);
    endtask

    initial begin
        {psel, penable, pwrite, rx_start, rx_copy, rx_reject, rx_err, rx_valid} = 8'h0;
        {rx_last, rx_fcs, rx_cfi, rx_tid, slow, fail, rx_pcp, rx_match} = 19'h0;
        {paddr, rx_vid, rx_len, rx_type} = 54'h0;
        {pwdata, rx_word, cfg_v} = 96'h0;
        rst_n = 1'b0;
        err_total = 0;
        samples_checked = 0;
        n = $urandom(56992);
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(rbdm_pkg::OFS_CFG, rbdm_pkg::CFG_RST);
        rd(rbdm_pkg::OFS_QPTR, rbdm_pkg::QPTR_RST);
        apb(1'b0, 12'h010, 32'h0);
        chk({rd_v[30:0], e_v}, 32'h1, "unmapped access");
        for (n = 0; n < 3; n++)
            u_rbdm_mem_model.mem[64 + 2 * n] = 32'h400 + n * 128 + (n == 2 ? 2 : 0);
        apb(1'b1, rbdm_pkg::OFS_QPTR, 32'h100);
        cfg_v = 32'h0000_8001;
        apb(1'b1, rbdm_pkg::OFS_CFG, cfg_v);
        rd(rbdm_pkg::OFS_QPTR, 32'h100);
        {rx_type, rx_vid, rx_tid} <= {16'h8100, 12'h0, 1'b1};
        {rx_pcp, rx_cfi, rx_match} <= 13'($urandom);
        n = 1 + $urandom % BUF;
        frame(n, 0, 1'b0);
        chk_buf(0, 0, n, 1'b1, 1'b1, 14'(n * 4));
        rd(rbdm_pkg::OFS_QPTR, 32'h108);
        {rx_type, rx_vid, rx_tid, rx_pcp, rx_cfi} <= {16'h0800, 12'h005, 5'h0};
        rx_match <= 9'($urandom);
        n = BUF + 1 + $urandom % BUF;
        frame(n, 1, 1'b0);
        chk_buf(1, 0, BUF, 1'b1, 1'b0, 14'(n * 4));
        chk_buf(2, BUF, n - BUF, 1'b0, 1'b1, 14'(n * 4));
        rd(rbdm_pkg::OFS_QPTR, 32'h100);
        // One last beat lets the discard finish and return to idle
        {rx_valid, rx_last} <= 2'b11;
        begin_frame(32'h100);
        {rx_valid, rx_last} <= 2'b00;
        chk(32'({bna_s, rse_s}), 32'h3, "used descriptor events");
        rd(rbdm_pkg::OFS_STAT, 32'h1);
        rd(rbdm_pkg::OFS_RSERR, 32'h1);
        apb(1'b1, rbdm_pkg::OFS_STAT, 32'h3);
        u_rbdm_mem_model.mem[64][0] = 1'b0;
        for (n = 1; n < 5; n++) abort(n);
        rd(rbdm_pkg::OFS_STAT, 32'h2);
        cfg_v = 32'h0002_8009;
        apb(1'b1, rbdm_pkg::OFS_CFG, cfg_v);
        n = 2 + $urandom % (BUF - 1);
        frame(n, 0, 1'b1);
        chk_buf(0, 0, n - 1, 1'b1, 1'b1, 14'(n * 4 - 4));
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        end_sim();
    end
endmodule
`default_nettype wire
